//--- rtl/sprc_ctrl.sv
// Standby entry, power gating and power-on reset sequencing controller
// Function
// R1: Enter standby on standby input toggle or external I2C/JTAG instruction.
// R2: Standby keeps device configured; user logic, I/O and memories stay running. Code gates every primary clock net off in standby.
// R3: Optionally switch bandgap off in standby; that kills POR, PLL, oscillator, diff I/O.
// R4: POR monitor may be off in standby; reduced power detector then stays active.
// R5: Oscillator can be disabled permanently, or automatically during standby.
// R6: PLL off statically or in standby, only after all outputs are low.
// R7: Differential I/O buffers switch off dynamically, per bank selection.
// R8: Each primary clock net has its own dynamic enable.
// R9: Input buffer gating for clock and data inputs, including in standby.
// R10: Start flash download only after core and config bank supplies are valid.
// R11: User I/O high impedance until configuration completes.
// R12: Optional user-mode core supply monitoring; drop reasserts reset and restarts.
// R13: Bandgap off selects low-power reset detector with lower trip level.
// R14: Serial-core standby and wake requests count only when wake feature enabled.
// R15: Timer wake interrupt is a standby exit source.
// R16: Wake restores bandgap first, then analog, oscillator, then clocks.
`default_nettype none
module sprc_ctrl #(
  parameter int NB = sprc_pkg::NUM_BANKS,
  parameter int NC = sprc_pkg::NUM_PCLK,
  parameter int NP = sprc_pkg::NUM_PLL_OUT,
  parameter int NI = sprc_pkg::NUM_INBUF,
  parameter int BG_CYC  = sprc_pkg::BG_SETTLE_CYC,
  parameter int OSC_CYC = sprc_pkg::OSC_SETTLE_CYC,
  parameter int CFG_CYC = sprc_pkg::CFG_LOAD_CYC
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Asynchronous request and supply inputs
  input  wire logic          standby_in,
  input  wire logic          ext_standby_cmd,
  input  wire logic          ext_wake_cmd,
  input  wire logic          serial_standby_req,
  input  wire logic          serial_wake_req,
  input  wire logic          timer_wake_irq,
  input  wire logic          core_supply_ok,
  input  wire logic          cfg_bank_supply_ok,
  input  wire logic          core_above_active_trip,
  input  wire logic          core_above_low_trip,
  input  wire logic [NP-1:0] pll_out_level,
  // Static configuration
  input  wire logic          cfg_bg_off_in_standby,
  input  wire logic          cfg_por_off_in_standby,
  input  wire logic          cfg_osc_disable,
  input  wire logic          cfg_osc_off_in_standby,
  input  wire logic          cfg_pll_disable,
  input  wire logic          cfg_pll_off_in_standby,
  input  wire logic          cfg_user_monitor_en,
  input  wire logic          cfg_wake_feature_en,
  // Dynamic user controls
  input  wire logic [NB-1:0] diff_io_off_sel,
  input  wire logic [NC-1:0] pclk_enable,
  input  wire logic [NI-1:0] inbuf_off_sel,
  input  wire logic [NI-1:0] inbuf_off_in_standby,
  input  wire logic          cfg_load_done,
  // Outputs
  output logic               in_standby,
  output logic               bandgap_en,
  output logic               por_main_en,
  output logic               por_low_en,
  output logic               low_trip_sel,
  output logic               osc_en,
  output logic               pll_en,
  output logic               pll_out_gate,
  output logic [NB-1:0]      diff_io_en,
  output logic [NC-1:0]      pclk_en,
  output logic [NI-1:0]      inbuf_en,
  output logic               cfg_download_start,
  output logic               user_io_oe_n,
  output logic               device_reset_n,
  output logic               user_mode
);
  typedef enum logic [3:0] {
    SPRC_POWERUP, SPRC_DOWNLOAD, SPRC_USER, SPRC_PLL_DRAIN, SPRC_STANDBY,
    SPRC_WAKE_BG, SPRC_WAKE_OSC
  } sprc_state_t;

  localparam int SW = 10;

  logic rst_meta_q;
  logic rst_q;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  logic [NP-1:0] pll_lvl_s;
  logic          stby_s;
  logic          ext_stby_s;
  logic          ext_wake_s;
  logic          ser_stby_s;
  logic          ser_wake_s;
  logic          tmr_wake_s;
  logic          core_ok_s;
  logic          bank_ok_s;
  logic          act_trip_s;
  logic          low_trip_s;

  sprc_state_t state_q;
  sprc_state_t state_d;
  logic        stby_prev_q;
  logic        ext_stby_prev_q;
  logic        bg_on_q;
  logic        osc_on_q;
  logic        pll_on_q;
  logic        pll_gate_q;
  logic [1:0]  gate_hist_q;
  logic        clocks_on_q;
  logic        dl_start_q;
  logic        io_oe_n_q;
  logic        dev_rst_n_q;
  logic        por_main_q;
  logic        por_low_q;
  logic        low_sel_q;
  logic        standby_q;
  logic [NB-1:0] diff_q;
  logic [NC-1:0] pclk_q;
  logic [NI-1:0] inbuf_q;

  logic                    tmr_load;
  logic [sprc_pkg::CNT_W-1:0] tmr_count;
  logic                    tmr_done;

  // Reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  assign sync_in = {standby_in, ext_standby_cmd, ext_wake_cmd, serial_standby_req,
                    serial_wake_req, timer_wake_irq, core_supply_ok,
                    cfg_bank_supply_ok, core_above_active_trip, core_above_low_trip};

  sprc_sync #(.W(SW)) u_sync (
    .clk   (clk),
    .rst_n (rst_q),
    .d     (sync_in),
    .q     (sync_out)
  );

  sprc_sync #(.W(NP)) u_sync_pll (
    .clk   (clk),
    .rst_n (rst_q),
    .d     (pll_out_level),
    .q     (pll_lvl_s)
  );

  assign {stby_s, ext_stby_s, ext_wake_s, ser_stby_s, ser_wake_s, tmr_wake_s,
          core_ok_s, bank_ok_s, act_trip_s, low_trip_s} = sync_out;

  sprc_timer #(.W(sprc_pkg::CNT_W)) u_timer (
    .clk   (clk),
    .rst_n (rst_q),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // Request decode
  wire stby_toggle  = stby_s != stby_prev_q;                                    // R1
  wire ext_stby_req = ext_stby_s && !ext_stby_prev_q;                           // R1
  wire ser_stby     = cfg_wake_feature_en && ser_stby_s;                        // R14
  wire ser_wake     = cfg_wake_feature_en && ser_wake_s;                        // R14
  wire enter_req    = stby_toggle || ext_stby_req || ser_stby;                  // R1
  wire wake_req     = stby_toggle || ext_wake_s || ser_wake || tmr_wake_s;      // R15
  wire supplies_ok  = core_ok_s && bank_ok_s;                                   // R10
  wire bg_gate      = cfg_bg_off_in_standby;                                    // R3
  wire pll_stby_off = cfg_pll_off_in_standby || bg_gate;                        // R6
  wire pll_all_low  = ~|pll_lvl_s;                                              // R6
  // Low samples trusted only once the gate has crossed the synchroniser
  wire pll_quiet    = (&gate_hist_q) && pll_all_low;                            // R6
  // Low trip when bandgap off, otherwise active trip
  wire trip_ok      = low_sel_q ? low_trip_s : act_trip_s;                      // R13
  wire supply_drop  = cfg_user_monitor_en && !trip_ok;                          // R12
  wire monitor_lost = (state_q == SPRC_USER || state_q == SPRC_STANDBY) && supply_drop;
  wire bg_off_now   = !bg_on_q;

  always_comb begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_count = sprc_pkg::CNT_ZERO;
    unique case (state_q)
      SPRC_POWERUP: begin
        if (supplies_ok) begin                                                  // R10
          state_d   = SPRC_DOWNLOAD;
          tmr_load  = 1'b1;
          tmr_count = sprc_pkg::CNT_W'(CFG_CYC);
        end
      end
      SPRC_DOWNLOAD: begin
        if (cfg_load_done || tmr_done) begin                                    // R11
          state_d = SPRC_USER;
        end
      end
      SPRC_USER: begin
        if (monitor_lost) begin                                                 // R12
          state_d = SPRC_POWERUP;
        end else if (enter_req) begin
          state_d = SPRC_PLL_DRAIN;
        end
      end
      SPRC_PLL_DRAIN: begin
        if (!pll_stby_off || pll_quiet) begin                                   // R6
          state_d = SPRC_STANDBY;
        end
      end
      SPRC_STANDBY: begin
        if (monitor_lost) begin                                                 // R12
          state_d = SPRC_POWERUP;
        end else if (wake_req) begin                                            // R16
          state_d   = SPRC_WAKE_BG;
          tmr_load  = 1'b1;
          tmr_count = bg_off_now ? sprc_pkg::CNT_W'(BG_CYC) : sprc_pkg::CNT_ONE;
        end
      end
      SPRC_WAKE_BG: begin
        if (tmr_done) begin                                                     // R16
          state_d   = SPRC_WAKE_OSC;
          tmr_load  = 1'b1;
          tmr_count = sprc_pkg::CNT_W'(OSC_CYC);
        end
      end
      SPRC_WAKE_OSC: begin
        if (tmr_done) begin                                                     // R16
          state_d = SPRC_USER;
        end
      end
      default: state_d = SPRC_POWERUP;
    endcase
  end

  wire st_user  = state_d == SPRC_USER;
  wire st_stby  = state_d == SPRC_STANDBY;
  wire st_wbg   = state_d == SPRC_WAKE_BG;
  wire st_dl    = state_d == SPRC_DOWNLOAD;
  wire st_drain = state_d == SPRC_PLL_DRAIN;
  wire st_run   = st_user || st_stby || st_drain || st_wbg || (state_d == SPRC_WAKE_OSC);

  // Analog enables for the next state
  wire bg_d      = !(st_stby && bg_gate);                                       // R3
  wire analog_up = bg_d && !st_wbg;                                             // R16
  wire osc_d     = !cfg_osc_disable && analog_up &&
                   !(st_stby && cfg_osc_off_in_standby);                        // R5
  wire pll_d     = !cfg_pll_disable && osc_d &&
                   !(st_stby && pll_stby_off);                                  // R6
  wire pll_want  = pll_d && st_run;                                             // R6
  wire por_m_d   = bg_d && !(st_stby && cfg_por_off_in_standby);                // R4
  wire clocks_d  = st_user;                                                     // R16

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      state_q         <= SPRC_POWERUP;
      stby_prev_q     <= 1'b0;
      ext_stby_prev_q <= 1'b0;
      bg_on_q         <= 1'b1;
      osc_on_q        <= 1'b0;
      pll_on_q        <= 1'b0;
      pll_gate_q      <= 1'b1;
      gate_hist_q     <= '0;
      clocks_on_q     <= 1'b0;
      dl_start_q      <= 1'b0;
      io_oe_n_q       <= 1'b1;
      dev_rst_n_q     <= 1'b0;
      por_main_q      <= 1'b1;
      por_low_q       <= 1'b1;
      low_sel_q       <= 1'b0;
      standby_q       <= 1'b0;
    end else begin
      state_q         <= state_d;
      stby_prev_q     <= stby_s;
      ext_stby_prev_q <= ext_stby_s;
      bg_on_q         <= bg_d;                                                  // R3
      osc_on_q        <= osc_d && st_run;                                       // R5
      pll_on_q        <= pll_want || (pll_on_q && !pll_quiet);                  // R6
      pll_gate_q      <= !clocks_d || st_drain || !pll_want;                    // R6
      gate_hist_q     <= {gate_hist_q[0], pll_gate_q};                          // R6
      clocks_on_q     <= clocks_d;                                              // R8
      dl_start_q      <= st_dl && (state_q == SPRC_POWERUP);                    // R10
      io_oe_n_q       <= !st_run;                                               // R11
      dev_rst_n_q     <= st_run;                                                // R12
      por_main_q      <= por_m_d;                                               // R4
      por_low_q       <= 1'b1;                                                  // R4
      low_sel_q       <= !bg_d;                                                 // R13
      standby_q       <= st_stby || st_drain;                                   // R2
    end
  end

  // Per-bank, per-net and per-buffer gating, registered
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      diff_q  <= '0;
      pclk_q  <= '0;
      inbuf_q <= '0;
    end else begin
      diff_q  <= (bg_d && st_run) ? ~diff_io_off_sel : '0;                      // R7
      pclk_q  <= clocks_d ? pclk_enable : '0;                                   // R8
      inbuf_q <= ~(inbuf_off_sel | (st_stby ? inbuf_off_in_standby : '0));      // R9
    end
  end

  assign in_standby         = standby_q;
  assign bandgap_en         = bg_on_q;
  assign por_main_en        = por_main_q;
  assign por_low_en         = por_low_q;
  assign low_trip_sel       = low_sel_q;
  assign osc_en             = osc_on_q;
  assign pll_en             = pll_on_q;
  assign pll_out_gate       = pll_gate_q;
  assign diff_io_en         = diff_q;
  assign pclk_en            = pclk_q;
  assign inbuf_en           = inbuf_q;
  assign cfg_download_start = dl_start_q;
  assign user_io_oe_n       = io_oe_n_q;
  assign device_reset_n     = dev_rst_n_q;
  assign user_mode          = clocks_on_q;
endmodule
`default_nettype wire

//--- rtl/sprc_pkg.sv
// Shared constants for the standby and power-on reset controller
`default_nettype none
package sprc_pkg;
  localparam int          NUM_BANKS      = 8;
  localparam int          NUM_PCLK       = 8;
  localparam int          NUM_PLL_OUT    = 4;
  localparam int          NUM_INBUF      = 8;
  // Settling and load times in ns, clock rate in MHz
  localparam int          BG_SETTLE_NS   = 1000;
  localparam int          OSC_SETTLE_NS  = 400;
  localparam int          CFG_LOAD_NS    = 2000;
  localparam int          CLK_MHZ        = 250;
  // Least times round up to whole cycles
  localparam int          BG_SETTLE_CYC  = (BG_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int          OSC_SETTLE_CYC = (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int          CFG_LOAD_CYC   = (CFG_LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W          = 16;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_ONE        = 16'h0001;
endpackage
`default_nettype wire

//--- rtl/sprc_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`default_nettype none
module sprc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- rtl/sprc_timer.sv
// Load-and-count-down delay timer with done flag
`default_nettype none
module sprc_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  assign done = run_q && (cnt_q == W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - W'(1);
      run_q <= (cnt_q != W'(1));
    end
  end
endmodule
`default_nettype wire

//--- verif/sprc_ctrl_checker.sv
// Concurrent checks on the standby and reset controller ports
`default_nettype none
module sprc_ctrl_checker #(parameter int NB = 8, parameter int NC = 8, parameter int NP = 4) (
  input wire logic          clk,
  input wire logic          reset_n,
  input wire logic          standby_in,
  input wire logic          core_supply_ok,
  input wire logic          cfg_bank_supply_ok,
  input wire logic          core_above_active_trip,
  input wire logic          cfg_user_monitor_en,
  input wire logic [NP-1:0] pll_out_level,
  input wire logic          in_standby,
  input wire logic          bandgap_en,
  input wire logic          por_main_en,
  input wire logic          por_low_en,
  input wire logic          low_trip_sel,
  input wire logic          osc_en,
  input wire logic          pll_en,
  input wire logic          pll_out_gate,
  input wire logic [NB-1:0] diff_io_en,
  input wire logic [NC-1:0] pclk_en,
  input wire logic          cfg_download_start,
  input wire logic          user_io_oe_n,
  input wire logic          device_reset_n,
  input wire logic          user_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_lost; user_mode && cfg_user_monitor_en && !core_above_active_trip; endsequence
  sequence s_toggle; user_mode && $changed(standby_in); endsequence
  property p_drop; s_lost |-> ##[0:6] !device_reset_n; endproperty
  a_drop: assert property (p_drop) else $error("no reset on supply loss");
  property p_enter; s_toggle |-> ##[1:8] in_standby; endproperty
  a_enter: assert property (p_enter) else $error("standby not entered");
  property p_tri; !device_reset_n |-> user_io_oe_n; endproperty
  a_tri: assert property (p_tri) else $error("io driven in reset");
  property p_user; user_mode |-> !user_io_oe_n && device_reset_n; endproperty
  a_user: assert property (p_user) else $error("io not released");
  property p_dl_once; cfg_download_start |=> !cfg_download_start; endproperty
  a_dl_once: assert property (p_dl_once) else $error("download pulse too long");
  property p_dl_ok; cfg_download_start |-> core_supply_ok && cfg_bank_supply_ok; endproperty
  a_dl_ok: assert property (p_dl_ok) else $error("download without supplies");
  property p_bg; !bandgap_en |-> !(osc_en || pll_en || por_main_en) && diff_io_en == '0; endproperty
  a_bg: assert property (p_bg) else $error("analog on without bandgap");
  property p_trip; !bandgap_en |-> low_trip_sel && por_low_en; endproperty
  a_trip: assert property (p_trip) else $error("low trip not selected");
  property p_drain; $fell(pll_en) |-> pll_out_gate && pll_out_level == '0; endproperty
  a_drain: assert property (p_drain) else $error("pll off with live outputs");
  property p_noclk; !user_mode |-> pclk_en == '0; endproperty
  a_noclk: assert property (p_noclk) else $error("clock net on outside user mode");
  property p_osc; $rose(osc_en) |-> $past(bandgap_en, 2); endproperty
  a_osc: assert property (p_osc) else $error("oscillator before bandgap");
endmodule
bind sprc_ctrl sprc_ctrl_checker #(.NB(NB), .NC(NC), .NP(NP)) u_chk (
  .clk, .reset_n, .standby_in, .core_supply_ok, .cfg_bank_supply_ok, .core_above_active_trip,
  .cfg_user_monitor_en, .pll_out_level, .in_standby, .bandgap_en, .por_main_en, .por_low_en,
  .low_trip_sel, .osc_en, .pll_en, .pll_out_gate, .diff_io_en, .pclk_en, .cfg_download_start,
  .user_io_oe_n, .device_reset_n, .user_mode);
`default_nettype wire

//--- verif/sprc_far.sv
// Far-side model: request sources, supply rails and PLL output clocks
`default_nettype none
module sprc_far #(parameter int NP = 4) (
  input  wire logic     clk,
  input  wire logic     pll_en,
  input  wire logic     pll_out_gate,
  output logic          standby_in,
  output logic          ext_standby_cmd,
  output logic          ext_wake_cmd,
  output logic          serial_standby_req,
  output logic          serial_wake_req,
  output logic          timer_wake_irq,
  output logic          core_supply_ok,
  output logic          cfg_bank_supply_ok,
  output logic          core_above_active_trip,
  output logic          core_above_low_trip,
  output logic [NP-1:0] pll_out_level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {standby_in, ext_standby_cmd, ext_wake_cmd, serial_standby_req, serial_wake_req} = 5'h0;
    {timer_wake_irq, core_supply_ok, cfg_bank_supply_ok, core_above_active_trip} = 4'h0;
    core_above_low_trip = 1'b0;
    pll_out_level = '0;
  end
  // Outputs run while enabled, then drop low one at a time once gated
  always @(posedge clk) begin
    pll_out_level <= (pll_en && !pll_out_gate) ? ~pll_out_level
                   : pll_out_level & (pll_out_level << 1);
  end
  task automatic req(input int k);
    @(negedge clk);
    case (k)
      0: standby_in = ~standby_in;
      1: ext_standby_cmd = 1'b1;
      2: serial_standby_req = 1'b1;
      3: ext_wake_cmd = 1'b1;
      4: timer_wake_irq = 1'b1;
      default: serial_wake_req = 1'b1;
    endcase
    repeat (6) @(negedge clk);
    {ext_standby_cmd, ext_wake_cmd, serial_standby_req, serial_wake_req, timer_wake_irq} = 5'h0;
  endtask
  task automatic rails(input logic [3:0] v);
    @(negedge clk);
    {core_supply_ok, cfg_bank_supply_ok, core_above_active_trip, core_above_low_trip} = v;
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Directed testbench for the standby and reset controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       cfg_bg_off_in_standby, cfg_por_off_in_standby, cfg_osc_disable;
  logic       cfg_osc_off_in_standby, cfg_pll_disable, cfg_pll_off_in_standby;
  logic       cfg_user_monitor_en, cfg_wake_feature_en, cfg_load_done, standby_in;
  logic       ext_standby_cmd, ext_wake_cmd, serial_standby_req, serial_wake_req;
  logic       timer_wake_irq, core_supply_ok, cfg_bank_supply_ok, core_above_active_trip;
  logic       core_above_low_trip, in_standby, bandgap_en, por_main_en, por_low_en;
  logic       low_trip_sel, osc_en, pll_en, pll_out_gate, cfg_download_start;
  logic       user_io_oe_n, device_reset_n, user_mode;
  logic [3:0] pll_out_level, m;
  logic [7:0] diff_io_off_sel, pclk_enable, inbuf_off_sel, inbuf_off_in_standby;
  logic [7:0] diff_io_en, pclk_en, inbuf_en;
  int         fail_count = 0;
  int         check_count = 0;
  int         dl_n = 0;
  int         ent [4] = '{0, 1, 2, 0};
  int         wak [4] = '{3, 4, 5, 0};
  logic [3:0] mode [4] = '{4'h0, 4'h3, 4'h8, 4'h4};

  always #2 clk = ~clk;
  always @(posedge clk) if (cfg_download_start === 1'b1) dl_n++;

  sprc_ctrl #(.BG_CYC(8), .OSC_CYC(6), .CFG_CYC(12)) u_dut (
    .clk, .reset_n, .standby_in, .ext_standby_cmd, .ext_wake_cmd, .serial_standby_req,
    .serial_wake_req, .timer_wake_irq, .core_supply_ok, .cfg_bank_supply_ok,
    .core_above_active_trip, .core_above_low_trip, .pll_out_level, .cfg_bg_off_in_standby,
    .cfg_por_off_in_standby, .cfg_osc_disable, .cfg_osc_off_in_standby, .cfg_pll_disable,
    .cfg_pll_off_in_standby, .cfg_user_monitor_en, .cfg_wake_feature_en, .diff_io_off_sel,
    .pclk_enable, .inbuf_off_sel, .inbuf_off_in_standby, .cfg_load_done, .in_standby,
    .bandgap_en, .por_main_en, .por_low_en, .low_trip_sel, .osc_en, .pll_en, .pll_out_gate,
    .diff_io_en, .pclk_en, .inbuf_en, .cfg_download_start, .user_io_oe_n, .device_reset_n,
    .user_mode);
  sprc_far u_far (
    .clk, .pll_en, .pll_out_gate, .standby_in, .ext_standby_cmd, .ext_wake_cmd,
    .serial_standby_req, .serial_wake_req, .timer_wake_irq, .core_supply_ok,
    .cfg_bank_supply_ok, .core_above_active_trip, .core_above_low_trip, .pll_out_level);

  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return user_mode;
      1: return in_standby;
      2: return device_reset_n;
      default: return dl_n != 0;
    endcase
  endfunction
  task automatic wt(input int s, input logic v);
    int k;
    k = 0;
    while (pick(s) !== v && k < 400) begin
      @(negedge clk);
      k++;
    end
    chk("wait", 24'h00_0001, {23'h0, pick(s) === v});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic complete_run;
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  initial begin
    {cfg_bg_off_in_standby, cfg_por_off_in_standby, cfg_osc_disable, cfg_osc_off_in_standby} = 4'h0;
    {cfg_pll_disable, cfg_pll_off_in_standby, cfg_user_monitor_en, cfg_wake_feature_en} = 4'h0;
    cfg_load_done = 1'b0;
    diff_io_off_sel = 8'h0F;
    pclk_enable = 8'h5A;
    inbuf_off_sel = 8'h33;
    inbuf_off_in_standby = 8'h0F;
    idle(10);
    reset_n = 1'b1;
    idle(20);
    chk("held", 24'h00_0001, {22'h0, device_reset_n, user_io_oe_n});
    u_far.rails(4'hB);
    idle(20);
    chk("dl_count", 24'h00_0000, dl_n[23:0]);
    u_far.rails(4'hF);
    wt(3, 1'b1);
    chk("io_in_dl", 24'h00_0001, {23'h0, user_io_oe_n});
    cfg_load_done = 1'b1;
    wt(0, 1'b1);
    chk("user", 24'h00_0002, {22'h0, device_reset_n, user_io_oe_n});
    idle(6);
    chk("gates", 24'hF0_5ACC, {diff_io_en, pclk_en, inbuf_en});
    {cfg_osc_disable, cfg_pll_disable} = 2'h3;
    idle(20);
    chk("static_off", 24'h00_0000, {22'h0, osc_en, pll_en});
    {cfg_osc_disable, cfg_pll_disable} = 2'h0;
    u_far.req(2);
    u_far.req(3);
    idle(10);
    chk("refused", 24'h00_0001, {22'h0, in_standby, user_mode});
    for (int i = 0; i < 4; i++) begin
      m = mode[i];
      {cfg_bg_off_in_standby, cfg_por_off_in_standby} = m[3:2];
      {cfg_osc_off_in_standby, cfg_pll_off_in_standby} = m[1:0];
      cfg_wake_feature_en = (i == 2);
      u_far.req(ent[i]);
      wt(1, 1'b1);
      idle(30);
      chk("standby", {m[3] ? 8'h00 : 8'hF0, 8'hC0, ~m[3], ~(m[3] | m[2]), ~(m[3] | m[1]),
          ~(m[3] | m[0]), m[3], 3'h4}, {diff_io_en, inbuf_en, bandgap_en, por_main_en,
          osc_en, pll_en, low_trip_sel, pll_out_gate, |pclk_en,
          user_io_oe_n | ~device_reset_n});
      u_far.req(wak[i]);
      wt(0, 1'b1);
      idle(4);
      chk("wake", 24'h0E_5ACC, {4'h0, bandgap_en, osc_en, pll_en, pll_out_gate, pclk_en,
          inbuf_en});
    end
    {cfg_bg_off_in_standby, cfg_por_off_in_standby, cfg_wake_feature_en} = 3'h4;
    cfg_user_monitor_en = 1'b1;
    diff_io_off_sel = 8'hA5;
    pclk_enable = 8'h3C;
    inbuf_off_sel = 8'h81;
    inbuf_off_in_standby = 8'hF0;
    u_far.req(0);
    wt(1, 1'b1);
    u_far.rails(4'hD);
    idle(10);
    chk("low_trip", 24'h00_0E01, {diff_io_en, inbuf_en, 7'h0, device_reset_n});
    u_far.rails(4'hE);
    wt(2, 1'b0);
    wt(0, 1'b1);
    chk("restart", 24'h00_0002, dl_n[23:0]);
    {cfg_user_monitor_en, cfg_load_done, cfg_bg_off_in_standby} = 3'h0;
    u_far.rails(4'h5);
    idle(10);
    chk("gates2", 24'h5A_3C7E, {diff_io_en, pclk_en, inbuf_en});
    chk("no_monitor", 24'h00_0001, {23'h0, device_reset_n});
    cfg_user_monitor_en = 1'b1;
    wt(2, 1'b0);
    chk("dropped", 24'h00_0002, {22'h0, user_io_oe_n, user_mode});
    u_far.rails(4'hF);
    idle(8);
    chk("dl_hold", 24'h00_000E, {dl_n[21:0], user_io_oe_n, user_mode});
    cfg_load_done = 1'b1;
    wt(0, 1'b1);
    chk("restart2", 24'h00_0003, dl_n[23:0]);
    complete_run();
  end
endmodule
`default_nettype wire
